// file: rtl/awbc_exec.v
// execute core for and-with-file and branch-on-carry, q1..q4 sequenced
// assumes i_instr is held stable by the fetch stage for a whole cycle
// assumes other instructions load w and file bytes via the write ports
`default_nettype none
`include "awbc_regs.vh"
module awbc_exec #(
   parameter PCW = `AWBC_PC_W
) (
   // clock and reset
   input wire i_mclk,
   input wire i_rst_b,
   // fetch pipeline
   input wire [15:0] i_instr,
   input wire i_instr_valid,
   input wire [PCW-1:0] i_pc,
   // core state
   input wire i_carry,
   input wire i_ext_set_en,
   input wire [`AWBC_BANK_W-1:0] i_bank_select_register,
   input wire [11:0] i_fsr2,
   // writes from the rest of the core
   input wire i_work_we,
   input wire [7:0] i_work_wdata,
   input wire i_ext_file_we,
   input wire [11:0] i_ext_file_addr,
   input wire [7:0] i_ext_file_wdata,
   // outputs
   output reg [1:0] o_phase,
   output reg [7:0] o_work,
   output reg o_pc_load,
   output reg [PCW-1:0] o_pc_target,
   output reg o_flush,
   output reg o_busy,
   output reg o_file_we,
   output reg [11:0] o_file_addr,
   output reg [7:0] o_file_wdata
);
   reg [1:0] phase;
   reg nop_cycle;
   reg [15:0] ir;
   reg is_and;
   reg is_br;
   reg [11:0] eff_addr;
   reg [7:0] result;
   wire [7:0] rdata;
   reg [11:0] next_addr;
   // decode of the word on i_instr, used at the q1 edge; next_target comes from ir and is used at q4
   reg next_is_and;
   reg next_is_br;
   reg [PCW-1:0] next_target;
   // shared write port of the file memory
   reg ram_we;
   reg [11:0] ram_waddr;
   reg [7:0] ram_wdata;

   // effective file address from a-bit, bank and extended mode
   function [11:0] awbc_ea;
      input [7:0] f;
      input a;
      input ext;
      input [3:0] bank;
      input [11:0] fsr2;
      begin
         if (!a && ext && f <= `AWBC_ILO_LIMIT) begin
            awbc_ea = fsr2 + {4'h0, f};
         end else if (!a) begin
            // access bank: low part of bank 0 or top of bank 15
            awbc_ea = (f < `AWBC_ACC_SPLIT) ? {4'h0, f} :
               {`AWBC_ACC_HI_BANK, f};
         end else begin
            awbc_ea = {bank, f};
         end
      end
   endfunction

   // and-with-file: 0001 01 d a ffff ffff
   function awbc_is_and;
      input [15:0] instr;
      begin
         awbc_is_and = instr[15:12] == `AWBC_OP_AND_HI &&
            instr[11:10] == `AWBC_OP_AND_MID;
      end
   endfunction

   // branch-on-carry: 1110 0010 nnnn nnnn
   function awbc_is_br;
      input [15:0] instr;
      begin
         awbc_is_br = instr[15:8] == `AWBC_OP_BR_HI;
      end
   endfunction

   // pc already points past the branch, so only 2n is added
   function [PCW-1:0] awbc_target;
      input [PCW-1:0] pc;
      input [7:0] n;
      begin
         awbc_target = pc + {{(PCW-9){n[7]}}, n, 1'b0};
      end
   endfunction

   // decode is combinational on the held word, latched at the q1 edge; next_target uses ir and is taken at q4
   always @* begin
      next_addr = awbc_ea(i_instr[7:0], i_instr[8], i_ext_set_en,
         i_bank_select_register, i_fsr2);
      next_is_and = !nop_cycle && i_instr_valid && awbc_is_and(i_instr);
      next_is_br = !nop_cycle && i_instr_valid && awbc_is_br(i_instr);
      next_target = awbc_target(i_pc, ir[7:0]);
   end

   // own q4 write wins; a colliding outside write is lost
   always @* begin
      ram_we = o_file_we | i_ext_file_we;
      ram_waddr = o_file_we ? o_file_addr : i_ext_file_addr;
      ram_wdata = o_file_we ? o_file_wdata : i_ext_file_wdata;
   end

   awbc_file_ram #(
      .AW(12),
      .DW(8)
   ) u_ram (
      .i_mclk(i_mclk),
      .i_raddr(eff_addr),
      .o_rdata(rdata),
      .i_we(ram_we),
      .i_waddr(ram_waddr),
      .i_wdata(ram_wdata)
   );

   // q-phase sequencer; o_phase shows the phase of the next edge
   // limitation: no stall input, the sequence never pauses
   always @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         phase <= `AWBC_Q1;
         o_phase <= `AWBC_Q1;
      end else begin
         phase <= phase + 2'h1;
         o_phase <= phase + 2'h1;
      end
   end

   always @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         nop_cycle <= 1'b0;
         ir <= 16'h0000;
         is_and <= 1'b0;
         is_br <= 1'b0;
         eff_addr <= 12'h000;
         result <= 8'h00;
         o_work <= 8'h00;
         o_pc_load <= 1'b0;
         o_pc_target <= {PCW{1'b0}};
         o_flush <= 1'b0;
         o_busy <= 1'b0;
         o_file_we <= 1'b0;
         o_file_addr <= 12'h000;
         o_file_wdata <= 8'h00;
      end else begin
         o_pc_load <= 1'b0;
         o_flush <= 1'b0;
         o_file_we <= 1'b0;
         // a write to w from elsewhere; own q4 result comes later
         if (i_work_we) begin
            o_work <= i_work_wdata;
         end
         case (phase)
            `AWBC_Q1: begin
               // q1: decode, unless this is the inserted dead cycle
               ir <= i_instr;
               is_and <= next_is_and;
               is_br <= next_is_br;
               eff_addr <= next_addr;
               o_busy <= nop_cycle;
            end
            `AWBC_Q2: begin
               // q2: ram returns file byte at eff_addr
            end
            `AWBC_Q3: begin
               // q3: and w with the file byte read in q2
               result <= o_work & rdata;
            end
            `AWBC_Q4: begin
               nop_cycle <= 1'b0;
               if (is_and) begin
                  if (ir[9]) begin
                     o_file_we <= 1'b1;
                     o_file_addr <= eff_addr;
                     o_file_wdata <= result;
                  end else begin
                     o_work <= result;
                  end
               end
               // untaken branch simply does nothing in q4
               if (is_br && i_carry) begin
                  o_pc_load <= 1'b1;
                  o_pc_target <= next_target;
                  o_flush <= 1'b1;
                  nop_cycle <= 1'b1;
                  o_busy <= 1'b1;
               end else if (is_br) begin
                  // carry clear: dead q4, pc just moves on
                  o_pc_load <= 1'b0;
               end
            end
            default: begin
               nop_cycle <= 1'b0;
            end
         endcase
      end
   end
endmodule
`default_nettype wire

// file: rtl/awbc_file_ram.v
// small file register memory, 4096 x 8, registered read data
// assumes one read and one write port, both on i_mclk
`default_nettype none
module awbc_file_ram #(
   parameter AW = 12,
   parameter DW = 8
) (
   // clock
   input wire i_mclk,
   // read port
   input wire [AW-1:0] i_raddr,
   output reg [DW-1:0] o_rdata,
   // write port
   input wire i_we,
   input wire [AW-1:0] i_waddr,
   input wire [DW-1:0] i_wdata
);
   reg [DW-1:0] mem [0:(1<<AW)-1];
   always @(posedge i_mclk) begin
      if (i_we) begin
         mem[i_waddr] <= i_wdata;
      end
      o_rdata <= mem[i_raddr];
   end
endmodule
`default_nettype wire

// file: rtl/awbc_regs.vh
// constants for the and-with-file / branch-on-carry execute block
// assumes inclusion by bare name from rtl files
`ifndef AWBC_REGS_VH
`define AWBC_REGS_VH
`define AWBC_OP_AND_HI 4'h1
`define AWBC_OP_AND_MID 2'h1
`define AWBC_OP_BR_HI 8'hE2
`define AWBC_ILO_LIMIT 8'h5F
`define AWBC_Q1 2'h0
`define AWBC_Q2 2'h1
`define AWBC_Q3 2'h2
`define AWBC_Q4 2'h3
`define AWBC_BANK_W 4
`define AWBC_PC_W 21
`define AWBC_FSR2_RST 12'h000
`define AWBC_ACC_SPLIT 8'h60
`define AWBC_ACC_HI_BANK 4'hF
`endif

// file: test/awbc_exec_bench.sv
// bench for awbc_exec: address and branch cases
// assumes instruction held for a whole cycle
`default_nettype none
module awbc_exec_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic i_mclk = 0, i_rst_b = 0, i_carry = 0, i_ext_set_en = 0;
   logic i_instr_valid = 1, i_work_we = 0, i_ext_file_we = 0;
   logic [15:0] i_instr = 0;
   logic [20:0] i_pc = 21'h1000, o_pc_target;
   logic [3:0] i_bank_select_register = 4'hA;
   logic [11:0] i_fsr2 = 12'h100, o_file_addr, i_ext_file_addr = 0;
   logic [7:0] o_work, o_file_wdata, i_work_wdata = 0, i_ext_file_wdata = 0;
   logic [1:0] o_phase;
   logic o_pc_load, o_flush, o_busy, o_file_we;
   int num_errors = 0, tests_run = 0;
   awbc_exec i_awbc_exec(.*);
   initial forever #2.5 i_mclk = ~i_mclk;
   task chk(string n, logic [20:0] s, e);
      tests_run++;
      num_errors += (s !== e);
      if (s !== e) $display("MISMATCH %s exp %h saw %h", n, e, s);
   endtask
   task summarize;
      $display("%0d checks, %0d errors", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // v stands q1..q4 of one cycle, n from the next; returns mid-cycle
   // after v's q4 edge, while its pulses still stand
   task issue(logic [15:0] v, n, logic vld);
      @(posedge i_mclk);
      while (o_phase !== 2'h3) @(posedge i_mclk);
      i_instr <= v;
      i_instr_valid <= vld;
      repeat (4) @(posedge i_mclk);
      i_instr <= n;
      i_instr_valid <= 1;
      @(negedge i_mclk);
   endtask
   // loads w and one file byte as other instructions would
   task preload(logic [7:0] w, logic [11:0] a, logic [7:0] d,
      logic ext, cy);
      @(posedge i_mclk);
      i_ext_set_en <= ext;
      i_carry <= cy;
      i_work_we <= 1;
      i_work_wdata <= w;
      i_ext_file_we <= 1;
      i_ext_file_addr <= a;
      i_ext_file_wdata <= d;
      @(posedge i_mclk);
      i_work_we <= 0;
      i_ext_file_we <= 0;
      @(negedge i_mclk);
   endtask
   task t_and;
      preload(8'h17, 12'hA34, 8'hC2, 0, 0);
      issue(16'h1734, 16'h0000, 1);
      chk("we", o_file_we, 1);
      chk("addr", o_file_addr, 12'hA34);
      chk("data", o_file_wdata, 8'h02);
      issue(16'h1534, 16'h0000, 1);
      chk("dest", o_file_we, 0);
      chk("work", o_work, 8'h02);
      preload(8'hFF, 12'h15F, 8'h5A, 1, 0);
      issue(16'h165F, 16'h0000, 1);
      chk("index", o_file_addr, 12'h15F);
      chk("idata", o_file_wdata, 8'h5A);
      preload(8'h0F, 12'hF60, 8'h3C, 1, 0);
      issue(16'h1660, 16'h0000, 1);
      chk("acc_hi", o_file_addr, 12'hF60);
      chk("hdata", o_file_wdata, 8'h0C);
      preload(8'hF0, 12'h034, 8'h96, 0, 0);
      issue(16'h1634, 16'h0000, 1);
      chk("acc_lo", o_file_addr, 12'h034);
      chk("ldata", o_file_wdata, 8'h90);
      issue(16'h1734, 16'h0000, 0);
      chk("invalid", o_file_we, 0);
      $display("t_and done");
   endtask
   task t_branch;
      issue(16'hE27F, 16'h0000, 1);
      chk("untaken", o_pc_load, 0);
      chk("ubusy", o_busy, 0);
      preload(8'hFF, 12'hA35, 8'h00, 0, 1);
      // a file write offered in the nop cycle must be dropped
      issue(16'hE280, 16'h1735, 1);
      chk("load", o_pc_load, 1);
      chk("flush", o_flush, 1);
      chk("target", o_pc_target, 21'h0F00);
      repeat (4) @(posedge i_mclk);
      @(negedge i_mclk);
      chk("nop", o_file_we, 0);
      chk("busy", o_busy, 1);
      @(posedge i_mclk);
      @(negedge i_mclk);
      chk("idle", o_busy, 0);
      issue(16'hE27F, 16'h0000, 1);
      chk("fwd", o_pc_target, 21'h10FE);
      @(posedge i_mclk);
      @(negedge i_mclk);
      chk("pulse", o_pc_load, 0);
      chk("fpulse", o_flush, 0);
      $display("t_branch done");
   endtask
   task t_reset;
      preload(8'hAA, 12'hA34, 8'hFF, 0, 0);
      @(posedge i_mclk);
      i_rst_b <= 0;
      repeat (2) @(posedge i_mclk);
      @(negedge i_mclk);
      chk("rphase", o_phase, 0);
      chk("rwork", o_work, 0);
      @(posedge i_mclk);
      i_rst_b <= 1;
      issue(16'h1734, 16'h0000, 1);
      chk("rwe", o_file_we, 1);
      $display("t_reset done");
   endtask
   initial begin
      repeat (12) @(posedge i_mclk);
      i_rst_b <= 1;
      t_and;
      t_branch;
      t_reset;
      summarize;
   end
   // tests need about 100 cycles; 1000 cycles leaves ample margin
   initial begin
      #5000;
      num_errors++;
      summarize;
   end
endmodule
`default_nettype wire

// file: test/awbc_exec_properties.sv
// checker for awbc_exec port timing
// assumes bind to the execute top, one clock
`default_nettype none
module awbc_exec_properties (
   input wire logic i_mclk, i_rst_b, i_carry, i_instr_valid,
   input wire logic [15:0] i_instr,
   input wire logic [20:0] i_pc, o_pc_target,
   input wire logic [1:0] o_phase,
   input wire logic o_pc_load, o_flush, o_busy, o_file_we);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge i_mclk); endclocking
   default disable iff (!i_rst_b);
   sequence s_wr; o_phase == 2'h0 && !o_busy && i_instr_valid &&
      i_instr[15:9] == 7'h0B;
   endsequence
   sequence s_wr0; o_phase == 2'h0 && !o_busy && i_instr_valid &&
      i_instr[15:9] == 7'h0A;
   endsequence
   sequence s_br; o_phase == 2'h3 && !o_busy && i_instr_valid &&
      i_instr[15:8] == 8'hE2;
   endsequence
   property p_tgt;
      logic [20:0] t;
      (s_br ##0 i_carry, t = i_pc + {{12{i_instr[7]}}, i_instr[7:0], 1'h0})
         |=> o_pc_target == t;
   endproperty
   chk_file_write: assert property (s_wr |-> ##4 o_file_we)
      else $error("no write");
   chk_jump_load: assert property (s_br ##0 i_carry |=> o_pc_load)
      else $error("no load");
   chk_no_jump: assert property (s_br ##0 !i_carry |=> !o_pc_load)
      else $error("bad load");
   chk_jump_target: assert property (p_tgt)
      else $error("bad target");
   chk_load_pulse: assert property (o_pc_load |=> !o_pc_load)
      else $error("long load");
   chk_nop_busy: assert property (o_pc_load |-> o_busy[*4])
      else $error("short nop");
   chk_nop_quiet: assert property (o_busy |-> !o_file_we)
      else $error("nop write");
   chk_flush_pair: assert property (o_flush == o_pc_load)
      else $error("lone flush");
   chk_keep_dest: assert property (s_wr0 |-> ##4 !o_file_we)
      else $error("w dest wrote file");
   chk_we_pulse: assert property (o_file_we |=> !o_file_we)
      else $error("long write");
endmodule
bind awbc_exec awbc_exec_properties i_chk(.*);
`default_nettype wire
